// *** design/link_control_status_register.sv ***
// Control and status register of one packet link port, with the link
// bring-up sequencer, error logging and stop-signal power handling.
// Assumes a same-clock register port and receiver event inputs; the
// warm reset, stop and link clock pins come from outside the clock.
`timescale 1ns/1ps
`default_nettype none
`include "link_ctl_consts.svh"

module link_control_status_register
  import link_ctl_pkg::*;
#(parameter int LONG_CTL_CYCLES = `LONG_CTL_NS / `CLK_PERIOD_NS)
(
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               warm_rst_n_i,
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic [`DATA_W-1:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [`DATA_W-1:0] rdata_o,
  input  wire logic               link_clk_i,
  input  wire logic               link_stop_n_i,
  input  wire logic [1:0]         rx_crc_err_i,
  input  wire logic               rx_sync_seen_i,
  input  wire logic               train_ok_i,
  input  wire logic               peer_absent_i,
  input  wire logic               connection_pending_i,
  input  wire logic [2:0]         neg_rx_width_i,
  input  wire logic [2:0]         neg_tx_width_i,
  input  wire logic [3:0]         reconnect_delay_i,
  output logic                    ctl_o,
  output logic                    tx_enable_o,
  output logic                    rx_enable_o,
  output logic                    crc_check_en_o,
  output logic                    flood_sync_o,
  output logic      [1:0]         bad_check_o,
  output logic                    link_oe_n_o,
  output logic                    link_clk_oe_n_o,
  output logic      [2:0]         rx_width_o,
  output logic      [2:0]         tx_width_o
);

  init_state_t state;
  init_state_t next_state;

  logic       warm_n_s, warm_n_q, stop_n_s, stop_n_q, lclk_s, lclk_q;
  logic       warm_hold, stop_fall, stop_rise, bit_edge;
  logic       error_flood_enable, inject_bad_check, connection_broken_flag;
  logic       training_done_flag, rx_shutdown, tx_shutdown;
  logic [1:0] lane_check_error;
  logic       stop_rx_power_down, stop_float_enable;
  logic       stop_float_clock_override, long_control_assert;
  logic [2:0] rx_used_width, tx_used_width;
  logic       negotiated_loaded;
  logic [11:0] recon_cnt;
  logic       ctl_start, ctl_done;

  logic       wr_hit, rd_hit, check_on, flood_hit, broken_set;
  logic [1:0] crc_ev, err_clr;
  logic [2:0] wr_rx_w, wr_tx_w;
  logic       rx_w_ok, tx_w_ok, apply_widths, load_negotiated;
  logic       recon_wait, floating, stop_active;
  logic [`DATA_W-1:0] rd_word;

  sync2 #(.WIDTH(3)) u_pin_sync
  (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({warm_rst_n_i, link_stop_n_i, link_clk_i}),
    .q_o       ({warm_n_s, stop_n_s, lclk_s})
  );

  // Edge stages reset like the synchroniser, so no false edge at release
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      warm_n_q <= 1'b0;
      stop_n_q <= 1'b0;
      lclk_q   <= 1'b0;
    end
    else
    begin
      warm_n_q <= warm_n_s;
      stop_n_q <= stop_n_s;
      lclk_q   <= lclk_s;
    end
  end

  assign warm_hold   = !warm_n_s;
  assign stop_fall   = stop_n_q && !stop_n_s;
  assign stop_rise   = !stop_n_q && stop_n_s;
  assign stop_active = !stop_n_s;
  // Double data rate link: each clock edge is one bit time
  assign bit_edge    = lclk_s ^ lclk_q;

  assign wr_hit  = wr_i && (addr_i == `REG_LINK_CTL);
  assign rd_hit  = rd_i && (addr_i == `REG_LINK_CTL);
  assign wr_rx_w = wdata_i[`F_RX_W_HI:`F_RX_W_LO];
  assign wr_tx_w = wdata_i[`F_TX_W_HI:`F_TX_W_LO];

  assign rx_w_ok = width_fits(wr_rx_w, `RX_PHYS_WIDTH);
  assign tx_w_ok = width_fits(wr_tx_w, `TX_PHYS_WIDTH);

  assign check_on = training_done_flag && rx_enable_o;
  assign crc_ev   = rx_crc_err_i & lane_mask(rx_width_o)
                    & {2{check_on}};
  assign flood_hit = (|crc_ev) && error_flood_enable;
  assign broken_set = flood_hit || flood_sync_o
                      || (rx_sync_seen_i && training_done_flag)
                      || (state == ST_ABSENT);
  assign err_clr = wr_hit ? wdata_i[`F_ERR_HI:`F_ERR_LO] : 2'h0;

  // new widths reach the link at warm release or stop disconnect
  assign apply_widths    = (warm_n_s && !warm_n_q)
                           || (stop_fall && state == ST_UP);
  assign load_negotiated = (state == ST_TRAIN) && train_ok_i
                           && !negotiated_loaded;

  // reconnect delay only when floating without clock override
  assign recon_wait = stop_float_enable && !stop_float_clock_override;
  assign floating   = (state == ST_STOP) && stop_float_enable;
  assign ctl_start  = (next_state == ST_CTL) && (state != ST_CTL);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:  next_state = ST_CTL;
      ST_CTL:    if (ctl_done) next_state = ST_TRAIN;
      ST_TRAIN:
      begin
        if (peer_absent_i)
          next_state = ST_ABSENT;
        else if (train_ok_i)
          next_state = ST_UP;
      end
      ST_UP:     if (stop_fall) next_state = ST_STOP;
      ST_ABSENT: next_state = ST_ABSENT;
      ST_STOP:
      begin
        if (stop_rise)
          next_state = recon_wait ? ST_RECON : ST_CTL;
      end
      ST_RECON:  if (recon_cnt == 12'h000) next_state = ST_CTL;
      default:   next_state = ST_RESET;
    endcase
    if (warm_hold)
      next_state = ST_RESET;
  end

  ctl_hold_timer #(.LONG_CYCLES(LONG_CTL_CYCLES)) u_ctl_timer
  (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (ctl_start),
    .long_i     (long_control_assert),
    .bit_edge_i (bit_edge),
    .done_o     (ctl_done)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state     <= ST_RESET;
      recon_cnt <= 12'h000;
    end
    else
    begin
      state <= next_state;
      if (stop_rise)
        recon_cnt <= 12'(reconnect_delay_i * `RECON_STEP_CYCLES);
      else if (state == ST_RECON && recon_cnt != 12'h000)
        recon_cnt <= recon_cnt - 12'h001;
    end
  end

  // volatile bits clear on cold or warm reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      error_flood_enable        <= 1'b0;
      inject_bad_check          <= 1'b0;
      rx_shutdown               <= 1'b0;
      tx_shutdown               <= 1'b0;
      stop_rx_power_down        <= 1'b0;
      stop_float_clock_override <= 1'b0;
      flood_sync_o              <= 1'b0;
      training_done_flag        <= 1'b0;
    end
    else if (warm_hold)
    begin
      error_flood_enable        <= 1'b0;
      inject_bad_check          <= 1'b0;
      rx_shutdown               <= 1'b0;
      tx_shutdown               <= 1'b0;
      stop_rx_power_down        <= 1'b0;
      stop_float_clock_override <= 1'b0;
      flood_sync_o              <= 1'b0;
      training_done_flag        <= 1'b0;
    end
    else
    begin
      if (wr_hit)
      begin
        error_flood_enable        <= wdata_i[`F_FLOOD];
        inject_bad_check          <= wdata_i[`F_INJECT];
        stop_rx_power_down        <= wdata_i[`F_STOP_RX];
        stop_float_clock_override <= wdata_i[`F_CLK_OVR];
      end
      rx_shutdown <= rx_shutdown || (wr_hit && wdata_i[`F_RX_OFF])
                     || (state == ST_ABSENT);
      tx_shutdown <= tx_shutdown || (wr_hit && wdata_i[`F_TX_OFF])
                     || (state == ST_ABSENT);
      flood_sync_o <= flood_sync_o || flood_hit;
      // done tracks the link being up
      training_done_flag <= (next_state == ST_UP);
    end
  end

  // sticky bits clear on cold reset only
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      connection_broken_flag <= 1'b0;
      lane_check_error       <= 2'h0;
      stop_float_enable      <= 1'b0;
      long_control_assert    <= 1'b0;
      rx_used_width          <= `WIDTH_RESET;
      tx_used_width          <= `WIDTH_RESET;
      negotiated_loaded      <= 1'b0;
    end
    else
    begin
      // write 1 clears, a new event wins
      connection_broken_flag <= broken_set || (connection_broken_flag
                                && !(wr_hit && wdata_i[`F_BROKEN]));
      // per-lane write 1 clear, set wins
      lane_check_error <= (lane_check_error & ~err_clr) | crc_ev;
      if (wr_hit)
      begin
        stop_float_enable   <= wdata_i[`F_FLOAT];
        long_control_assert <= wdata_i[`F_LONG_CTL];
      end
      if (load_negotiated)
      begin
        rx_used_width     <= neg_rx_width_i;
        tx_used_width     <= neg_tx_width_i;
        negotiated_loaded <= 1'b1;
      end
      else if (wr_hit)
      begin
        if (rx_w_ok)
          rx_used_width <= wr_rx_w;
        if (tx_w_ok)
          tx_used_width <= wr_tx_w;
      end
    end
  end

  // Link-facing outputs, all registered
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_width_o      <= `WIDTH_RESET;
      tx_width_o      <= `WIDTH_RESET;
      ctl_o           <= 1'b0;
      tx_enable_o     <= 1'b0;
      rx_enable_o     <= 1'b0;
      crc_check_en_o  <= 1'b0;
      bad_check_o     <= 2'h0;
      link_oe_n_o     <= 1'b0;
      link_clk_oe_n_o <= 1'b0;
    end
    else
    begin
      // applied width is what the far receiver must match
      if (load_negotiated)
      begin
        rx_width_o <= neg_rx_width_i;
        tx_width_o <= neg_tx_width_i;
      end
      else if (apply_widths)
      begin
        rx_width_o <= rx_used_width;
        tx_width_o <= tx_used_width;
      end
      // a shut transmitter freezes ctl_o and holds tx_enable_o low
      if (!tx_shutdown)
        ctl_o <= (next_state == ST_CTL);
      tx_enable_o <= !tx_shutdown && (state == ST_UP);
      // receiver off during stop when enabled
      rx_enable_o <= !rx_shutdown
                     && !(stop_active && stop_rx_power_down);
      crc_check_en_o <= check_on;
      // corrupt CRC on used outgoing lanes
      bad_check_o <= inject_bad_check ? lane_mask(tx_width_o) : 2'h0;
      link_oe_n_o <= floating;
      link_clk_oe_n_o <= floating && !stop_float_clock_override;
    end
  end

  // unmapped reads, self-test, isoc and dword bits read zero
  always_comb
  begin
    rd_word = '0;
    rd_word[`F_FLOOD]  = error_flood_enable;
    rd_word[`F_INJECT] = inject_bad_check;
    rd_word[`F_BROKEN] = connection_broken_flag && !connection_pending_i;
    rd_word[`F_DONE]   = training_done_flag;
    rd_word[`F_RX_OFF] = rx_shutdown;
    rd_word[`F_TX_OFF] = tx_shutdown;
    rd_word[`F_ERR_HI:`F_ERR_LO] = lane_check_error
                                   & lane_mask(rx_width_o);
    rd_word[`F_STOP_RX]  = stop_rx_power_down;
    rd_word[`F_FLOAT]    = stop_float_enable;
    rd_word[`F_LONG_CTL] = long_control_assert;
    rd_word[`F_CLK_OVR]  = stop_float_clock_override;
    rd_word[`F_RX_MAX_HI:`F_RX_MAX_LO] = `RX_PHYS_WIDTH;
    rd_word[`F_TX_MAX_HI:`F_TX_MAX_LO] = `TX_PHYS_WIDTH;
    rd_word[`F_RX_W_HI:`F_RX_W_LO]     = rx_used_width;
    rd_word[`F_TX_W_HI:`F_TX_W_LO]     = tx_used_width;
    if (!rd_hit)
      rd_word = '0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else
      rdata_o <= rd_word;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_flood_off_quiet: assert property (
    $rose(flood_sync_o) |-> $past(error_flood_enable))
    else $error("flood started with flooding disabled");

  a_flood_on_emit: assert property (
    (flood_hit && !warm_hold) |=> flood_sync_o && connection_broken_flag)
    else $error("crc error with flooding on did not flood");

  a_const_zero_bits: assert property (
    rdata_o[`F_SELFTEST] == 1'b0 && rdata_o[`F_ISOC] == 1'b0
    && rdata_o[`F_RX_DW_CAP] == 1'b0 && rdata_o[`F_TX_DW_CAP] == 1'b0
    && rdata_o[`F_RX_DW_EN] == 1'b0 && rdata_o[`F_TX_DW_EN] == 1'b0)
    else $error("constant-zero field read nonzero");

  a_inject_lanes: assert property (
    inject_bad_check
    |=> bad_check_o == lane_mask($past(tx_width_o)))
    else $error("bad check not on every used lane");

  a_broken_clear: assert property (
    (wr_hit && wdata_i[`F_BROKEN] && !broken_set)
    |=> !connection_broken_flag)
    else $error("failure flag did not clear on write of one");

  sequence s_trained;
    state == ST_TRAIN && train_ok_i && !peer_absent_i && !warm_hold;
  endsequence

  a_done_after_train: assert property (
    $rose(training_done_flag) |-> $past(state == ST_TRAIN && train_ok_i))
    else $error("init done set without successful bring-up");

  a_train_sets_done: assert property (
    s_trained |=> training_done_flag
    ##1 (crc_check_en_o == $past(rx_enable_o)))
    else $error("bring-up success not reflected");

  a_check_after_init: assert property (
    crc_check_en_o |-> $past(training_done_flag))
    else $error("crc checking before init complete");

  a_rx_off_sticky: assert property (
    rx_shutdown && !warm_hold |=> rx_shutdown)
    else $error("receiver shutdown cleared without reset");

  a_tx_off_frozen: assert property (
    tx_shutdown && !warm_hold |=> $stable(ctl_o) && !tx_enable_o)
    else $error("link output moved while transmitter off");

  a_stop_rx_off: assert property (
    stop_active && stop_rx_power_down |=> !rx_enable_o)
    else $error("receiver on during stop with disable set");

  a_clk_override: assert property (
    stop_float_clock_override |=> !link_clk_oe_n_o)
    else $error("link clock floated despite override");

  a_width_reject: assert property (
    wr_hit && !rx_w_ok && !load_negotiated |=> $stable(rx_used_width))
    else $error("inconsistent width was stored");

endmodule

`default_nettype wire

// *** design/link_ctl_consts.svh ***
// Offsets, field positions, reset values and timing for the link control
// and status register block. Included by the package, the register block and the hold timer.
`ifndef LINK_CTL_CONSTS_SVH
`define LINK_CTL_CONSTS_SVH

`define CLK_PERIOD_NS     4
`define REG_LINK_CTL      8'h84
`define ADDR_W            8
`define DATA_W            32

`define F_FLOOD           1
`define F_SELFTEST        2
`define F_INJECT          3
`define F_BROKEN          4
`define F_DONE            5
`define F_RX_OFF          6
`define F_TX_OFF          7
`define F_ERR_HI          9
`define F_ERR_LO          8
`define F_STOP_RX         11
`define F_ISOC            12
`define F_FLOAT           13
`define F_LONG_CTL        14
`define F_CLK_OVR         15
`define F_RX_MAX_HI       18
`define F_RX_MAX_LO       16
`define F_RX_DW_CAP       19
`define F_TX_MAX_HI       22
`define F_TX_MAX_LO       20
`define F_TX_DW_CAP       23
`define F_RX_W_HI         26
`define F_RX_W_LO         24
`define F_RX_DW_EN        27
`define F_TX_W_HI         30
`define F_TX_W_LO         28
`define F_TX_DW_EN        31

`define RX_PHYS_WIDTH     3'h1
`define TX_PHYS_WIDTH     3'h1
`define WIDTH_RESET       3'h0
`define WIDTH_NC          3'h7

`define CTL_BIT_TIMES     16
`define LONG_CTL_NS       50000
`define RECON_STEP_CYCLES 12'h040
`define BIT_CNT_W         16

`endif

// *** design/link_ctl_pkg.sv ***
// Types and width decoding shared by the link control blocks.
// Assumes link_ctl_consts.svh is on the include path.
`include "link_ctl_consts.svh"

package link_ctl_pkg;

  typedef enum logic [2:0]
  {
    ST_RESET  = 3'h0,
    ST_CTL    = 3'h1,
    ST_TRAIN  = 3'h2,
    ST_UP     = 3'h3,
    ST_ABSENT = 3'h4,
    ST_STOP   = 3'h5,
    ST_RECON  = 3'h6
  } init_state_t;

  // lane count per width code; reserved and unconnected give zero
  function automatic logic [5:0] lanes_of(input logic [2:0] code);
    case (code)
      3'h0:    lanes_of = 6'h08;
      3'h1:    lanes_of = 6'h10;
      3'h3:    lanes_of = 6'h20;
      3'h4:    lanes_of = 6'h02;
      3'h5:    lanes_of = 6'h04;
      default: lanes_of = 6'h00;
    endcase
  endfunction

  function automatic logic width_fits(input logic [2:0] code,
                                      input logic [2:0] max_code);
    width_fits = (lanes_of(code) != 6'h00) &&
                 (lanes_of(code) <= lanes_of(max_code));
  endfunction

  // Byte lanes in use: narrow links live on lane 0
  function automatic logic [1:0] lane_mask(input logic [2:0] code);
    if (lanes_of(code) == 6'h00)
      lane_mask = 2'h0;
    else if (lanes_of(code) >= 6'h10)
      lane_mask = 2'h3;
    else
      lane_mask = 2'h1;
  endfunction

endpackage

// *** design/sync2.sv ***
// Two flip-flop synchroniser for levels arriving from outside sys_clk_i.
// Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(parameter int WIDTH = 1)
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

// *** design/ctl_hold_timer.sv ***
// Times how long the control line is held during link initialization:
// a number of link bit times, or a long interval in system cycles.
// Expects bit_edge_i as a one-cycle pulse per link bit time.
`timescale 1ns/1ps
`default_nettype none
`include "link_ctl_consts.svh"

module ctl_hold_timer
  import link_ctl_pkg::*;
#(parameter int LONG_CYCLES = 12500)
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic long_i,
  input  wire logic bit_edge_i,
  output logic      done_o
);

  logic [`BIT_CNT_W-1:0] remain;
  logic                  running;
  logic                  step;

  // Short hold counts link bit times, long hold counts system cycles
  assign step = running && (long_i || bit_edge_i);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      remain  <= '0;
      running <= 1'b0;
      done_o  <= 1'b0;
    end
    else if (start_i)
    begin
      remain  <= long_i ? `BIT_CNT_W'(LONG_CYCLES)
                        : `BIT_CNT_W'(`CTL_BIT_TIMES);
      running <= 1'b1;
      done_o  <= 1'b0;
    end
    else if (step)
    begin
      remain  <= remain - `BIT_CNT_W'(1);
      running <= (remain != `BIT_CNT_W'(1));
      done_o  <= (remain == `BIT_CNT_W'(1));
    end
    else
      done_o <= 1'b0;
  end

endmodule

`default_nettype wire

// *** tb/peer_link_model.sv ***
// Far-end link peer: clocks the link during the control hold, then trains.
// Assumes ctl_i comes straight from the block under test.
`timescale 1ns/1ps
`default_nettype none
module peer_link_model
(
  input  wire logic sys_clk_i,
  input  wire logic ctl_i,
  output logic      link_clk_o,
  output logic      train_ok_o
);
  logic ctl_q;
  initial link_clk_o = 1'b0;
  // bit times
  // Clock stands still outside the control hold
  always #16 if (ctl_i) link_clk_o = ~link_clk_o;
  always_ff @(posedge sys_clk_i)
  begin
    ctl_q      <= ctl_i;
    train_ok_o <= ctl_q & ~ctl_i;
  end
endmodule
`default_nettype wire

// *** tb/link_control_status_register_bench.sv ***
// Bench for the link control and status register block.
// Assumes the peer model answers each control hold with training.
`timescale 1ns/1ps
`default_nettype none
module link_control_status_register_bench;
  localparam logic [31:0] W = 32'h5100_0000;
  logic        clk, rst_n, wrst_n, wr, rd, lclk, tok, ctl;
  logic        txe, rxe, crce, fl;
  logic        stp_n, sy, pend, loe, lcoe;
  logic [7:0]  a;
  logic [31:0] wd, rdat, d;
  logic [1:0]  err, bc;
  logic [2:0]  rxw, txw;
  int          n_mismatch, num_checks;

  link_control_status_register #(.LONG_CTL_CYCLES(50))
    link_control_status_register_i (.sys_clk_i(clk), .rst_n_i(rst_n),
    .warm_rst_n_i(wrst_n), .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdat), .link_clk_i(lclk), .link_stop_n_i(stp_n),
    .rx_crc_err_i(err), .rx_sync_seen_i(sy), .train_ok_i(tok),
    .peer_absent_i(1'b0), .connection_pending_i(pend),
    .neg_rx_width_i(3'h1), .neg_tx_width_i(3'h5), .reconnect_delay_i(4'h0),
    .ctl_o(ctl), .tx_enable_o(txe), .rx_enable_o(rxe),
    .crc_check_en_o(crce), .flood_sync_o(fl), .bad_check_o(bc),
    .link_oe_n_o(loe), .link_clk_oe_n_o(lcoe), .rx_width_o(rxw),
    .tx_width_o(txw));
  peer_link_model peer_link_model_i (.sys_clk_i(clk), .ctl_i(ctl),
    .link_clk_o(lclk), .train_ok_o(tok));

  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wrt(input logic [31:0] v);
    @(posedge clk);
    a  <= 8'h84;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdr;
    @(posedge clk);
    a  <= 8'h84;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task upw;
    for (int i = 0; i < 4000 && txe !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (txe !== 1'b1)
    begin
      n_mismatch++;
      summarize;
    end
  endtask
  task pulse(input logic [1:0] v);
    @(posedge clk);
    err <= v;
    @(posedge clk);
    err <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task s_bringup;
    rdr;
    chk("reset word", 32'h0011_0000, d);
    upw;
    repeat (2) @(posedge clk);
    chk("check en", 32'h1, {31'h0, crce});
    rdr;
    chk("up word", 32'h5111_0020, d);
  endtask
  task s_width;
    wrt(32'h7300_0000);
    rdr;
    chk("bad width", 32'h5111_0020, d);
    wrt(32'h5400_0000);
    rdr;
    chk("good width", 32'h5411_0020, d);
    wrt(W);
  endtask
  task s_flood;
    pulse(2'h3);
    chk("no flood", 32'h0, {31'h0, fl});
    rdr;
    chk("lane errs", 32'h5111_0320, d);
    wrt(W | 32'h300);
    rdr;
    chk("lane clear", 32'h5111_0020, d);
    wrt(W | 32'h2);
    pulse(2'h1);
    chk("flood", 32'h1, {31'h0, fl});
    rdr;
    chk("fail set", 32'h5111_0132, d);
  endtask
  task s_off;
    wrt(W | 32'h8);
    @(posedge clk);
    #1;
    chk("bad check", 32'h1, {30'h0, bc});
    wrt(W | 32'hC0);
    repeat (2) @(posedge clk);
    chk("enables", 32'h0, {30'h0, rxe, txe});
    wrt(W);
    rdr;
    chk("off bits", 32'h3, {30'h0, d[7:6]});
  endtask
  task s_warm;
    @(posedge clk);
    wrst_n <= 1'b0;
    repeat (6) @(posedge clk);
    wrst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("flood off", 32'h0, {31'h0, fl});
    rdr;
    chk("warm word", 32'h5111_0110, d);
    upw;
    wrt(W | 32'h10);
    rdr;
    chk("fail clear", 32'h5111_0120, d);
  endtask
  task s_stop;
    @(posedge clk);
    sy   <= 1'b1;
    pend <= 1'b1;
    @(posedge clk);
    sy <= 1'b0;
    rdr;
    chk("fail hidden", 32'h5111_0120, d);
    @(posedge clk);
    pend <= 1'b0;
    rdr;
    chk("sync fail", 32'h5111_0130, d);
    wrt(32'h4400_2800);
    chk("link width", 32'h0D, {26'h0, rxw, txw});
    chk("driven", 32'h0, {30'h0, loe, lcoe});
    @(posedge clk);
    stp_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("stop rx off", 32'h0, {31'h0, rxe});
    chk("floated", 32'h3, {30'h0, loe, lcoe});
    chk("new width", 32'h24, {26'h0, rxw, txw});
    wrt(32'h4400_A800);
    @(posedge clk);
    #1;
    chk("clk driven", 32'h2, {30'h0, loe, lcoe});
    @(posedge clk);
    stp_n <= 1'b1;
    upw;
    chk("rx back", 32'h1, {31'h0, rxe});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst_n, wr, rd, a, wd, err, sy, pend, n_mismatch, num_checks} = '0;
    {wrst_n, stp_n} = 2'h3;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_bringup;
    s_width;
    s_flood;
    s_off;
    s_warm;
    s_stop;
    summarize;
  end
endmodule
`default_nettype wire
